/* core/i2c_flag_pkg.sv */
// Package: register map, field positions and carriers for the bus flag block
package i2c_flag_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [15:0] FLAG_REG_ADDR     = 16'hffab;
  localparam logic [15:0] CLKSEL_REG_ADDR   = 16'hffa8;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  FLAG_REG_RESET    = 8'h00;
  localparam logic [7:0]  CLKSEL_REG_RESET  = 8'h00;

  // ==========================================================
  // Flag register fields
  localparam int unsigned START_FAIL_BIT    = 7;
  localparam int unsigned BUS_BUSY_BIT      = 6;
  localparam int unsigned INIT_START_BIT    = 1;
  localparam int unsigned RSV_DISABLE_BIT   = 0;

  // ==========================================================
  // Clock select register fields
  localparam int unsigned CLK_LEVEL_BIT     = 5;
  localparam int unsigned DATA_LEVEL_BIT    = 4;
  localparam logic [7:0]  CLKSEL_WR_MASK    = 8'h0f;

  // ==========================================================
  // Line event indices
  localparam int unsigned EVT_START         = 0;
  localparam int unsigned EVT_STOP          = 1;
  localparam int unsigned EVT_COUNT         = 2;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wdata;
  } cpu_req_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } line_pins_t;

  typedef struct packed {
    logic start_fail_flag;
    logic bus_busy_flag;
    logic initial_start_enable;
    logic reservation_disable;
  } flag_state_t;

endpackage

/* core/i2c_line_monitor.sv */
// Link-side start and stop detector, reporting events as toggles
`timescale 1ns/1ps
module i2c_line_monitor (
  input  wire logic                      link_clk_i,
  input  wire logic                      rst_i,
  input  wire i2c_flag_pkg::line_pins_t  pins_i,
  output logic [i2c_flag_pkg::EVT_COUNT-1:0] event_toggle_o
);
  import i2c_flag_pkg::*;

  // ==========================================================
  // Pin synchronisers and history
  line_pins_t                 meta;
  line_pins_t                 sync;
  line_pins_t                 prev;
  logic [EVT_COUNT-1:0]       next_event_toggle;
  logic                       start_seen;
  logic                       stop_seen;

  always_comb begin
    start_seen = prev.scl & sync.scl & prev.sda & ~sync.sda;
    stop_seen  = prev.scl & sync.scl & ~prev.sda & sync.sda;
    next_event_toggle = event_toggle_o;
    next_event_toggle[EVT_START] = event_toggle_o[EVT_START] ^ start_seen;
    next_event_toggle[EVT_STOP]  = event_toggle_o[EVT_STOP] ^ stop_seen;
  end

  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta           <= '1;
      sync           <= '1;
      prev           <= '1;
      event_toggle_o <= '0;
    end else begin
      meta           <= pins_i;
      sync           <= meta;
      prev           <= sync;
      event_toggle_o <= next_event_toggle;
    end
  end

endmodule

/* core/i2c_event_sync.sv */
// System-side toggle synchroniser turning link events into one-cycle pulses
`timescale 1ns/1ps
module i2c_event_sync (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_i,
  input  wire logic [i2c_flag_pkg::EVT_COUNT-1:0] toggle_i,
  output logic      [i2c_flag_pkg::EVT_COUNT-1:0] pulse_o
);
  import i2c_flag_pkg::*;

  logic [EVT_COUNT-1:0] meta;
  logic [EVT_COUNT-1:0] sync;
  logic [EVT_COUNT-1:0] last;
  logic [EVT_COUNT-1:0] next_pulse;

  // ==========================================================
  // Edge detect per event
  genvar g;
  generate
    for (g = 0; g < EVT_COUNT; g++) begin : gen_evt
      always_comb begin
        next_pulse[g] = sync[g] ^ last[g];
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta    <= '0;
      sync    <= '0;
      last    <= '0;
      pulse_o <= '0;
    end else begin
      meta    <= toggle_i;
      sync    <= meta;
      last    <= sync;
      pulse_o <= next_pulse;
    end
  end

endmodule

/* core/i2c_bus_flag_status.sv */
// Bus flag register, clock select register and start permission logic
`timescale 1ns/1ps
module i2c_bus_flag_status (
  input  wire logic                      sys_clk_i,
  input  wire logic                      link_clk_i,
  input  wire logic                      rst_i,
  input  wire i2c_flag_pkg::cpu_req_t    cpu_req_i,
  output logic [7:0]                     cpu_rdata_o,
  output logic                           cpu_rvalid_o,
  input  wire logic                      bus_enable_i,
  input  wire logic                      start_request_i,
  input  wire logic                      start_attempt_fail_i,
  input  wire i2c_flag_pkg::line_pins_t  pins_i,
  output i2c_flag_pkg::flag_state_t      flags_o,
  output logic                           start_permit_o,
  output logic [3:0]                     clock_select_o,
  output logic                           start_detect_o,
  output logic                           stop_detect_o
);
  import i2c_flag_pkg::*;

  // ==========================================================
  // Line event crossing
  logic [EVT_COUNT-1:0] event_toggle;
  logic [EVT_COUNT-1:0] event_pulse;

  i2c_line_monitor u_monitor (
    .link_clk_i     (link_clk_i),
    .rst_i          (rst_i),
    .pins_i         (pins_i),
    .event_toggle_o (event_toggle)
  );

  i2c_event_sync u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .toggle_i  (event_toggle),
    .pulse_o   (event_pulse)
  );

  // ==========================================================
  // Pin level synchronisers
  line_pins_t pin_meta;
  line_pins_t pin_sync;

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_meta <= '1;
      pin_sync <= '1;
    end else begin
      pin_meta <= pins_i;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================================
  // Address decode
  function automatic logic hit(input cpu_req_t req, input logic [15:0] addr);
    hit = (req.addr == addr);
  endfunction

  // ==========================================================
  // Flag state
  flag_state_t next_flags;
  logic        enable_prev;
  logic        stop_seen;
  logic        next_stop_seen;
  logic        next_start_permit;
  logic        enable_rise;
  logic        start_evt;
  logic        stop_evt;
  logic        flag_wr;

  always_comb begin
    start_evt   = event_pulse[EVT_START];
    stop_evt    = event_pulse[EVT_STOP];
    enable_rise = bus_enable_i & ~enable_prev;
    flag_wr     = cpu_req_i.wr & hit(cpu_req_i, FLAG_REG_ADDR);
    next_flags  = flags_o;

    // Start-fail flag: a failure while reservation_disable is set wins over a clearing request
    if (!bus_enable_i) begin
      next_flags.start_fail_flag = 1'b0;
    end else if (start_attempt_fail_i && flags_o.reservation_disable) begin
      next_flags.start_fail_flag = 1'b1;
    end else if (start_request_i) begin
      next_flags.start_fail_flag = 1'b0;
    end

    // Busy flag: a start wins over a stop in the same cycle
    if (!bus_enable_i) begin
      next_flags.bus_busy_flag = 1'b0;
    end else if (start_evt || (enable_rise && !flags_o.initial_start_enable)) begin
      next_flags.bus_busy_flag = 1'b1;
    end else if (stop_evt) begin
      next_flags.bus_busy_flag = 1'b0;
    end

    // Software bits, writable only while the bus is disabled
    if (flag_wr && !bus_enable_i) begin
      next_flags.initial_start_enable = cpu_req_i.wdata[INIT_START_BIT];
      next_flags.reservation_disable  = cpu_req_i.wdata[RSV_DISABLE_BIT];
    end
    if (start_evt) begin
      next_flags.initial_start_enable = 1'b0;
    end

    // Permission to generate a start
    next_stop_seen = stop_seen;
    if (!bus_enable_i) begin
      next_stop_seen = 1'b0;
    end else if (stop_evt) begin
      next_stop_seen = 1'b1;
    end else if (enable_rise && flags_o.initial_start_enable) begin
      next_stop_seen = 1'b1;
    end
    next_start_permit = bus_enable_i & next_stop_seen & ~next_flags.bus_busy_flag;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flags_o        <= '0;
      enable_prev    <= 1'b0;
      stop_seen      <= 1'b0;
      start_permit_o <= 1'b0;
    end else begin
      flags_o        <= next_flags;
      enable_prev    <= bus_enable_i;
      stop_seen      <= next_stop_seen;
      start_permit_o <= next_start_permit;
    end
  end

  // ==========================================================
  // Clock select register and line levels
  logic [3:0] next_clock_select;
  line_pins_t levels;
  line_pins_t next_levels;
  logic       next_start_detect;
  logic       next_stop_detect;

  always_comb begin
    next_clock_select = clock_select_o;
    if (cpu_req_i.wr && hit(cpu_req_i, CLKSEL_REG_ADDR) && !bus_enable_i) begin
      next_clock_select = cpu_req_i.wdata[3:0] & CLKSEL_WR_MASK[3:0];
    end
    next_levels       = bus_enable_i ? pin_sync : '0;
    next_start_detect = start_evt & bus_enable_i;
    next_stop_detect  = stop_evt & bus_enable_i;
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clock_select_o <= CLKSEL_REG_RESET[3:0];
      levels         <= '0;
      start_detect_o <= 1'b0;
      stop_detect_o  <= 1'b0;
    end else begin
      clock_select_o <= next_clock_select;
      levels         <= next_levels;
      start_detect_o <= next_start_detect;
      stop_detect_o  <= next_stop_detect;
    end
  end

  // ==========================================================
  // Read path
  logic [7:0] next_rdata;
  logic       next_rvalid;

  always_comb begin
    next_rdata  = 8'h00;
    next_rvalid = cpu_req_i.rd;
    if (cpu_req_i.rd && hit(cpu_req_i, FLAG_REG_ADDR)) begin
      next_rdata[START_FAIL_BIT]  = flags_o.start_fail_flag;
      next_rdata[BUS_BUSY_BIT]    = flags_o.bus_busy_flag;
      next_rdata[INIT_START_BIT]  = flags_o.initial_start_enable;
      next_rdata[RSV_DISABLE_BIT] = flags_o.reservation_disable;
    end else if (cpu_req_i.rd && hit(cpu_req_i, CLKSEL_REG_ADDR)) begin
      next_rdata[3:0]            = clock_select_o;
      next_rdata[CLK_LEVEL_BIT]  = levels.scl;
      next_rdata[DATA_LEVEL_BIT] = levels.sda;
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpu_rdata_o  <= FLAG_REG_RESET;
      cpu_rvalid_o <= 1'b0;
    end else begin
      cpu_rdata_o  <= next_rdata;
      cpu_rvalid_o <= next_rvalid;
    end
  end

endmodule

/* dv/i2c_line_model.sv */
// Far-side bus model: other parties making start and stop conditions
`timescale 1ns/1ps
module i2c_line_model (
  output i2c_flag_pkg::line_pins_t pins_o
);
  // ==========
  // Idle lines rest at the pull-up level
  initial pins_o = 2'b11;
  task automatic start_cond();
    pins_o.sda = 1'b0;
    #400;
    pins_o.scl = 1'b0;
    #400;
  endtask
  task automatic stop_cond();
    pins_o.scl = 1'b0;
    #400;
    pins_o.sda = 1'b0;
    #400;
    pins_o.scl = 1'b1;
    #400;
    pins_o.sda = 1'b1;
    #400;
  endtask
endmodule

/* dv/i2c_bus_flag_status_monitor.sv */
// Checker for the bus flag block, bound to its ports
`timescale 1ns/1ps
module i2c_bus_flag_status_monitor (
  input wire logic                      sys_clk_i,
  input wire logic                      rst_i,
  input wire i2c_flag_pkg::cpu_req_t    cpu_req_i,
  input wire logic [7:0]                cpu_rdata_o,
  input wire logic                      cpu_rvalid_o,
  input wire logic                      bus_enable_i,
  input wire logic                      start_request_i,
  input wire logic                      start_attempt_fail_i,
  input wire i2c_flag_pkg::flag_state_t flags_o,
  input wire logic [3:0]                clock_select_o,
  input wire logic                      start_detect_o
);
  import i2c_flag_pkg::*;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // Sequences
  sequence rd_any;
    cpu_req_i.rd;
  endsequence
  sequence rd_flag;
    cpu_req_i.rd && cpu_req_i.addr == FLAG_REG_ADDR;
  endsequence
  // ==========
  // Properties
  read_answer_a: assert property (rd_any |=> cpu_rvalid_o) else $error("read not answered");
  spare_bits_a: assert property (rd_flag |=> cpu_rdata_o[5:2] == 4'h0) else $error("spare bits set");
  disable_clear_a: assert property (!bus_enable_i |=> !flags_o.bus_busy_flag && !flags_o.start_fail_flag)
    else $error("flags kept while disabled");
  fail_set_a: assert property (bus_enable_i && start_attempt_fail_i && flags_o.reservation_disable
    |=> flags_o.start_fail_flag) else $error("start fail not set");
  fail_clear_a: assert property (start_request_i && !start_attempt_fail_i |=> !flags_o.start_fail_flag)
    else $error("start fail not cleared");
  start_seen_a: assert property (start_detect_o |-> flags_o.bus_busy_flag && !flags_o.initial_start_enable)
    else $error("start effect missing");
  enable_busy_a: assert property ($rose(bus_enable_i) && !flags_o.initial_start_enable
    |=> flags_o.bus_busy_flag) else $error("busy not set at enable");
  rsv_by_write_a: assert property ($changed(flags_o.reservation_disable)
    |-> $past(cpu_req_i.wr) && !$past(bus_enable_i)) else $error("reservation bit changed alone");
  clksel_locked_a: assert property (bus_enable_i |=> $stable(clock_select_o))
    else $error("clock select changed while enabled");
endmodule
bind i2c_bus_flag_status i2c_bus_flag_status_monitor mon_u (.sys_clk_i, .rst_i, .cpu_req_i, .cpu_rdata_o,
  .cpu_rvalid_o, .bus_enable_i, .start_request_i, .start_attempt_fail_i, .flags_o, .clock_select_o,
  .start_detect_o);

/* dv/i2c_bus_flag_status_tb.sv */
// Testbench for the bus flag block
`timescale 1ns/1ps
module i2c_bus_flag_status_tb;
  import i2c_flag_pkg::*;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        rst = 1'b1;
  logic        en = 1'b0;
  logic        sreq = 1'b0;
  logic        sfail = 1'b0;
  logic        seen = 1'b0;
  logic        seen_stop = 1'b0;
  logic [3:0]  csel;
  logic        sdet;
  logic        pdet;
  cpu_req_t    req = '0;
  logic [7:0]  rdata;
  logic        rvalid;
  logic        permit;
  line_pins_t  pins;
  flag_state_t flags;
  int          fails = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  always #2.5 sys_clk = ~sys_clk;
  initial begin
    #7;
    forever #40 link_clk = ~link_clk;
  end
  i2c_line_model line_u (.pins_o(pins));
  i2c_bus_flag_status dut_u (.sys_clk_i(sys_clk), .link_clk_i(link_clk), .rst_i(rst), .cpu_req_i(req),
    .cpu_rdata_o(rdata), .cpu_rvalid_o(rvalid), .bus_enable_i(en), .start_request_i(sreq),
    .start_attempt_fail_i(sfail), .pins_i(pins), .flags_o(flags), .start_permit_o(permit),
    .clock_select_o(csel), .start_detect_o(sdet), .stop_detect_o(pdet));
  always @(posedge sys_clk) begin
    if (sdet === 1'b1) seen <= 1'b1;
    if (pdet === 1'b1) seen_stop <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      fails++;
      conclude();
    end
  end
  // ==========
  // Shared tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) req <= '{a, 1'b1, 1'b0, d};
    @(posedge sys_clk) req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk) req <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge sys_clk) req <= '0;
    #1;
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk(what, exp, rdata);
  endtask
  task automatic pulse(input logic is_fail);
    @(posedge sys_clk);
    if (is_fail) sfail <= 1'b1;
    else sreq <= 1'b1;
    @(posedge sys_clk);
    sfail <= 1'b0;
    sreq <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic set_en(input logic v);
    @(posedge sys_clk) en <= v;
    repeat (6) @(posedge sys_clk);
  endtask
  // ==========
  // Scenarios
  task automatic t_config();
    rd(FLAG_REG_ADDR, 8'h00, "flag reset");
    rd(CLKSEL_REG_ADDR, 8'h00, "clksel reset");
    rd(16'hffaa, 8'h00, "unmapped");
    wr(FLAG_REG_ADDR, 8'hff);
    rd(FLAG_REG_ADDR, 8'h03, "flag written");
    wr(CLKSEL_REG_ADDR, 8'hff);
    rd(CLKSEL_REG_ADDR, 8'h0f, "clksel written");
    chk("clksel out", 8'h0f, {4'h0, csel});
  endtask
  task automatic t_enabled();
    set_en(1'b1);
    wr(FLAG_REG_ADDR, 8'h00);
    wr(CLKSEL_REG_ADDR, 8'h00);
    rd(FLAG_REG_ADDR, 8'h03, "flag locked");
    rd(CLKSEL_REG_ADDR, 8'h3f, "clksel locked");
    chk("permit init", 8'h01, {7'h00, permit});
  endtask
  task automatic t_start_stop();
    line_u.start_cond();
    chk("start seen", 8'h01, {7'h00, seen});
    rd(FLAG_REG_ADDR, 8'h41, "after start");
    chk("permit busy", 8'h00, {7'h00, permit});
    line_u.stop_cond();
    rd(FLAG_REG_ADDR, 8'h01, "after stop");
    chk("stop seen", 8'h01, {7'h00, seen_stop});
    chk("permit stop", 8'h01, {7'h00, permit});
  endtask
  task automatic t_fail();
    pulse(1'b1);
    rd(FLAG_REG_ADDR, 8'h81, "fail set");
    pulse(1'b0);
    rd(FLAG_REG_ADDR, 8'h01, "fail cleared");
    pulse(1'b1);
    set_en(1'b0);
    rd(FLAG_REG_ADDR, 8'h01, "disabled");
    rd(CLKSEL_REG_ADDR, 8'h0f, "levels off");
  endtask
  task automatic t_no_init();
    wr(FLAG_REG_ADDR, 8'h00);
    set_en(1'b1);
    rd(FLAG_REG_ADDR, 8'h40, "busy at enable");
    chk("permit wait", 8'h00, {7'h00, permit});
    pulse(1'b1);
    rd(FLAG_REG_ADDR, 8'h40, "reserved fail");
    line_u.stop_cond();
    rd(FLAG_REG_ADDR, 8'h00, "released");
    chk("permit free", 8'h01, {7'h00, permit});
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    t_config();
    $display("test config done");
    t_enabled();
    $display("test enabled done");
    t_start_stop();
    $display("test start stop done");
    t_fail();
    $display("test fail done");
    t_no_init();
    $display("test no init done");
    conclude();
  end
endmodule
